/* File: hdl/uhcf_command_fields.sv */
// module: host command fields, async-advance doorbell, schedule enables, APB slave
//
// Overview of operation
// - threshold field selects maximum interrupt interval of 1 to 64 micro-frames.
// - threshold resets to eight micro-frames, one millisecond.
// - park mode field always reads zero.
// - light reset bit is read-only zero.
// - after cache eviction the async-advance status flag is set.
// - doorbell clears itself after the status flag is set.
// - flag with enable raises interrupt at next threshold boundary.
// - async schedule enable resets to zero, gates async list fetching.
// - periodic schedule enable resets to zero, gates periodic list fetching.
//
// Decided for this implementation: register access over APB and the address map.
`timescale 1ns/10ps
module uhcf_command_fields
    import uhcf_pkg::*;
(
    // clock and reset
    input  wire logic                          mclk,
    input  wire logic                          srst,
    // apb slave
    input  wire logic                          psel,
    input  wire logic                          penable,
    input  wire logic                          pwrite,
    input  wire logic [uhcf_pkg::ADDR_W-1:0]   paddr,
    input  wire logic [uhcf_pkg::DATA_W-1:0]   pwdata,
    input  wire logic [uhcf_pkg::STRB_W-1:0]   pstrb,
    output logic      [uhcf_pkg::DATA_W-1:0]   prdata,
    output logic                               pready,
    output logic                               pslverr,
    // schedule engine
    input  wire logic                          asyncAdvanceDone,
    output logic                               doorbellRequest,
    output logic                               asyncScheduleEnable,
    output logic                               periodicScheduleEnable,
    output logic      [uhcf_pkg::DATA_W-1:0]   asyncListPointer,
    output logic      [uhcf_pkg::DATA_W-1:0]   periodicListPointer,
    output logic      [uhcf_pkg::THRESH_W-1:0] thresholdCode,
    // frame timer and interrupt
    input  wire logic                          microFrameTick,
    output logic                               irqOut
);

    // ------------------------------------------------------------
    // declarations
    // ------------------------------------------------------------
    uhcf_db_state_type   dbState;
    uhcf_db_state_type   next_dbState;

    logic                asyncAdvFlag;
    logic                asyncAdvIrqEnable;
    logic                next_asyncAdvFlag;

    logic [DATA_W-1:0]   byteMask;
    logic                setupPhase;
    logic                accessPhase;
    logic                wrStrobe;
    logic                hitCommand;
    logic                hitStatus;
    logic                hitIrqEn;
    logic                hitPeriodic;
    logic                hitAsync;
    logic                addrMapped;

    logic                wrCommand;
    logic                wrStatus;
    logic                wrIrqEn;
    logic                wrPeriodic;
    logic                wrAsync;

    logic                ringDoorbell;
    logic                clearAdvFlag;
    logic                doorbellBit;

    logic [DATA_W-1:0]   commandView;
    logic [DATA_W-1:0]   statusView;
    logic [DATA_W-1:0]   irqEnView;
    logic [DATA_W-1:0]   readMux;
    logic [THRESH_W-1:0] next_threshold;
    logic [DATA_W-1:0]   next_asyncPtr;
    logic [DATA_W-1:0]   next_periodicPtr;
    logic                irqLine;

    // ------------------------------------------------------------
    // apb decode
    // ------------------------------------------------------------
    // setup phase loads the answer; the access phase completes with no wait
    assign setupPhase  = psel && !penable;
    assign accessPhase = psel && penable && pready;
    assign wrStrobe    = accessPhase && pwrite && !pslverr;

    // address compare on whole words; low two bits must be zero
    assign hitCommand  = (paddr == OFF_COMMAND);
    assign hitStatus   = (paddr == OFF_STATUS);
    assign hitIrqEn    = (paddr == OFF_IRQ_EN);
    assign hitPeriodic = (paddr == OFF_PERIODIC);
    assign hitAsync    = (paddr == OFF_ASYNC);
    assign addrMapped  = hitCommand || hitStatus || hitIrqEn || hitPeriodic || hitAsync;

    // per-register write strobes
    assign wrCommand   = wrStrobe && hitCommand;
    assign wrStatus    = wrStrobe && hitStatus;
    assign wrIrqEn     = wrStrobe && hitIrqEn;
    assign wrPeriodic  = wrStrobe && hitPeriodic;
    assign wrAsync     = wrStrobe && hitAsync;

    // byte lanes expanded to a bit mask
    assign byteMask = {{8{pstrb[3]}}, {8{pstrb[2]}}, {8{pstrb[1]}}, {8{pstrb[0]}}};

    // ------------------------------------------------------------
    // command register: next values
    // ------------------------------------------------------------
    // only the threshold, the doorbell and two enables are stored; all else is dropped
    assign next_threshold = wrCommand && pstrb[2]
                          ? pwdata[CMD_THRESH_MSB:CMD_THRESH_LSB]
                          : thresholdCode;

    // doorbell is set by a written one only; a written zero does nothing
    assign ringDoorbell = wrCommand && pstrb[0] && pwdata[CMD_DOORBELL];

    // ------------------------------------------------------------
    // schedule list pointers: byte-lane merge
    // ------------------------------------------------------------
    assign next_asyncPtr    = (asyncListPointer & ~byteMask) | (pwdata & byteMask);
    assign next_periodicPtr = (periodicListPointer & ~byteMask) | (pwdata & byteMask);

    // ------------------------------------------------------------
    // doorbell handshake
    // ------------------------------------------------------------
    // flagged state gives one cycle in which the flag is up and the bell still reads one
    always_comb begin
        next_dbState = dbState;
        case (dbState)
            DB_IDLE: begin
                if (ringDoorbell) begin
                    next_dbState = DB_RUNG;
                end
            end
            DB_RUNG: begin
                if (asyncAdvanceDone) begin
                    next_dbState = DB_FLAGGED;
                end
            end
            DB_FLAGGED: begin
                // a fresh ring here starts a new request rather than being lost
                next_dbState = ringDoorbell ? DB_RUNG : DB_IDLE;
            end
            default: begin
                next_dbState = DB_IDLE;
            end
        endcase
    end

    assign doorbellBit = (dbState != DB_IDLE);

    // ------------------------------------------------------------
    // async-advance status flag
    // ------------------------------------------------------------
    // write-one-to-clear; an eviction in the same cycle keeps the flag set
    assign clearAdvFlag = wrStatus && pstrb[0] && pwdata[STS_ASYNC_ADV];
    assign next_asyncAdvFlag = ((dbState == DB_RUNG) && asyncAdvanceDone)
                             || (asyncAdvFlag && !clearAdvFlag);

    // ------------------------------------------------------------
    // read views
    // ------------------------------------------------------------
    // park mode, light reset and reserved bytes are constant zero
    always_comb begin
        commandView                                = {DATA_W{1'b0}};
        commandView[CMD_THRESH_MSB:CMD_THRESH_LSB] = thresholdCode;
        commandView[CMD_DOORBELL]                  = doorbellBit;
        commandView[CMD_ASYNC_EN]                  = asyncScheduleEnable;
        commandView[CMD_PERIOD_EN]                 = periodicScheduleEnable;
    end

    always_comb begin
        statusView                = {DATA_W{1'b0}};
        statusView[STS_ASYNC_ADV] = asyncAdvFlag;
    end

    always_comb begin
        irqEnView                = {DATA_W{1'b0}};
        irqEnView[STS_ASYNC_ADV] = asyncAdvIrqEnable;
    end

    // read selection; unmapped words read as zero with an error
    assign readMux = hitCommand  ? commandView
                   : hitStatus   ? statusView
                   : hitIrqEn    ? irqEnView
                   : hitPeriodic ? periodicListPointer
                   : hitAsync    ? asyncListPointer
                   : {DATA_W{1'b0}};

    // ------------------------------------------------------------
    // apb answer
    // ------------------------------------------------------------
    // ready is a flop so it never combines with paddr on the way out
    always_ff @(posedge mclk) begin
        if (srst) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= {DATA_W{1'b0}};
        end else if (setupPhase) begin
            pready  <= 1'b1;
            pslverr <= !addrMapped;
            prdata  <= pwrite ? {DATA_W{1'b0}} : readMux;
        end else begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // command register storage
    // ------------------------------------------------------------
    // bits 31:24, 15:7 and 3:0 have no storage, so writes cannot reach them
    always_ff @(posedge mclk) begin
        if (srst) begin
            thresholdCode <= RST_THRESH;
        end else begin
            thresholdCode <= next_threshold;
        end
    end

    // schedule enables, low byte lane
    always_ff @(posedge mclk) begin
        if (srst) begin
            asyncScheduleEnable    <= RST_ENABLE;
            periodicScheduleEnable <= RST_ENABLE;
        end else if (wrCommand && pstrb[0]) begin
            asyncScheduleEnable    <= pwdata[CMD_ASYNC_EN];
            periodicScheduleEnable <= pwdata[CMD_PERIOD_EN];
        end
    end

    // ------------------------------------------------------------
    // doorbell state and request output
    // ------------------------------------------------------------
    always_ff @(posedge mclk) begin
        if (srst) begin
            dbState         <= DB_IDLE;
            doorbellRequest <= 1'b0;
        end else begin
            dbState         <= next_dbState;
            doorbellRequest <= (next_dbState == DB_RUNG);
        end
    end

    // ------------------------------------------------------------
    // status and interrupt enable storage
    // ------------------------------------------------------------
    always_ff @(posedge mclk) begin
        if (srst) begin
            asyncAdvFlag <= 1'b0;
        end else begin
            asyncAdvFlag <= next_asyncAdvFlag;
        end
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            asyncAdvIrqEnable <= 1'b0;
        end else if (wrIrqEn && pstrb[0]) begin
            asyncAdvIrqEnable <= pwdata[STS_ASYNC_ADV];
        end
    end

    // ------------------------------------------------------------
    // schedule list pointers
    // ------------------------------------------------------------
    // held whole; alignment of the pointers is left to the schedule engine
    always_ff @(posedge mclk) begin
        if (srst) begin
            asyncListPointer <= RST_POINTER;
        end else if (wrAsync) begin
            asyncListPointer <= next_asyncPtr;
        end
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            periodicListPointer <= RST_POINTER;
        end else if (wrPeriodic) begin
            periodicListPointer <= next_periodicPtr;
        end
    end

    // ------------------------------------------------------------
    // interrupt pacing
    // ------------------------------------------------------------
    // enable and flag are combined before the pacer so masking drops the line at once
    uhcf_irq_pacer u_pacer (
        .mclk           (mclk),
        .srst           (srst),
        .microFrameTick (microFrameTick),
        .thresholdCode  (thresholdCode),
        .eventPending   (asyncAdvFlag && asyncAdvIrqEnable),
        .irqLine        (irqLine)
    );

    // pacer output is already a flop; re-register keeps the top output style uniform
    always_ff @(posedge mclk) begin
        if (srst) begin
            irqOut <= 1'b0;
        end else begin
            irqOut <= irqLine;
        end
    end

endmodule // uhcf_command_fields

/* File: hdl/uhcf_irq_pacer.sv */
// module: paces the interrupt line to the programmed micro-frame threshold
`timescale 1ns/10ps
module uhcf_irq_pacer
    import uhcf_pkg::*;
(
    // clock and reset
    input  wire logic                          mclk,
    input  wire logic                          srst,
    // pacing inputs
    input  wire logic                          microFrameTick,
    input  wire logic [uhcf_pkg::THRESH_W-1:0] thresholdCode,
    input  wire logic                          eventPending,
    // interrupt
    output logic                               irqLine
);

    logic [THRESH_W-1:0] tickCount;
    logic [THRESH_W-1:0] tickCountInc;
    logic                atBoundary;

    // ------------------------------------------------------------
    // boundary detect
    // ------------------------------------------------------------
    // the reserved code zero gives a boundary on every tick; harmless, just faster
    assign tickCountInc = tickCount + 8'h01;
    assign atBoundary   = microFrameTick && (tickCountInc >= thresholdCode);

    // micro-frame counter, restarts at each boundary
    always_ff @(posedge mclk) begin
        if (srst) begin
            tickCount <= 8'h00;
        end else if (atBoundary) begin
            tickCount <= 8'h00;
        end else if (microFrameTick) begin
            tickCount <= tickCountInc;
        end
    end

    // line rises only at a boundary, drops as soon as nothing is pending
    always_ff @(posedge mclk) begin
        if (srst) begin
            irqLine <= 1'b0;
        end else if (!eventPending) begin
            irqLine <= 1'b0;
        end else if (atBoundary) begin
            irqLine <= 1'b1;
        end
    end

endmodule // uhcf_irq_pacer

/* File: hdl/uhcf_pkg.sv */
// package: offsets, field layout, reset values and states of the host command fields block
package uhcf_pkg;

    // ------------------------------------------------------------
    // bus geometry
    // ------------------------------------------------------------
    localparam int unsigned ADDR_W   = 12;
    localparam int unsigned DATA_W   = 32;
    localparam int unsigned STRB_W   = 4;
    localparam int unsigned THRESH_W = 8;

    // ------------------------------------------------------------
    // register byte offsets
    // ------------------------------------------------------------
    localparam logic [ADDR_W-1:0] OFF_COMMAND  = 12'h000;
    localparam logic [ADDR_W-1:0] OFF_STATUS   = 12'h004;
    localparam logic [ADDR_W-1:0] OFF_IRQ_EN   = 12'h008;
    localparam logic [ADDR_W-1:0] OFF_PERIODIC = 12'h014;
    localparam logic [ADDR_W-1:0] OFF_ASYNC    = 12'h018;

    // ------------------------------------------------------------
    // command register field positions
    // ------------------------------------------------------------
    localparam int unsigned CMD_THRESH_LSB = 16;
    localparam int unsigned CMD_THRESH_MSB = 23;
    localparam int unsigned CMD_DOORBELL   = 6;
    localparam int unsigned CMD_ASYNC_EN   = 5;
    localparam int unsigned CMD_PERIOD_EN  = 4;

    // status and interrupt enable: async-advance flag position
    localparam int unsigned STS_ASYNC_ADV  = 5;

    // ------------------------------------------------------------
    // threshold codes, in micro-frames
    // ------------------------------------------------------------
    localparam logic [THRESH_W-1:0] THRESH_RESERVED = 8'h00;
    localparam logic [THRESH_W-1:0] THRESH_1        = 8'h01;
    localparam logic [THRESH_W-1:0] THRESH_8        = 8'h08;
    localparam logic [THRESH_W-1:0] THRESH_64       = 8'h40;

    // ------------------------------------------------------------
    // values after reset
    // ------------------------------------------------------------
    localparam logic [THRESH_W-1:0] RST_THRESH   = THRESH_8;
    localparam logic                RST_ENABLE   = 1'b0;
    localparam logic [DATA_W-1:0]   RST_POINTER  = 32'h0000_0000;
    localparam logic [DATA_W-1:0]   RST_COMMAND  = 32'h0008_0000;

    // doorbell handshake, gray coded along idle -> rung -> flagged
    typedef enum logic [1:0] {
        DB_IDLE    = 2'b00,
        DB_RUNG    = 2'b01,
        DB_FLAGGED = 2'b11
    } uhcf_db_state_type;

endpackage : uhcf_pkg

/* File: tb/uhcf_command_fields_properties.sv */
// checker: concurrent properties of the host command fields block
`timescale 1ns/10ps
module uhcf_command_fields_checker
    import uhcf_pkg::*;
(
    // clock and reset
    input wire logic        mclk,
    input wire logic        srst,
    // apb
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0]  pstrb,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    // schedule engine and interrupt
    input wire logic        asyncAdvanceDone,
    input wire logic        doorbellRequest,
    input wire logic        asyncScheduleEnable,
    input wire logic        periodicScheduleEnable,
    input wire logic [7:0]  thresholdCode,
    input wire logic        microFrameTick,
    input wire logic        irqOut
);
    default clocking dc @(posedge mclk); endclocking
    default disable iff (srst);

    // ------------------------------------------------------------
    // decode helpers
    // ------------------------------------------------------------
    // a completed command write, and a setup cycle to a hole in the map
    wire cmdWrite = psel && penable && pwrite && pready && (paddr == OFF_COMMAND);
    wire holeSetup = psel && !penable &&
        !(paddr inside {OFF_COMMAND, OFF_STATUS, OFF_IRQ_EN, OFF_PERIODIC, OFF_ASYNC});
    wire bellWrite = cmdWrite && pstrb[0] && pwdata[CMD_DOORBELL];

    // ------------------------------------------------------------
    // properties
    // ------------------------------------------------------------
    chk_zero_wait: assert property (psel && !penable |=> pready)
        else $error("pready missing in access cycle");
    chk_ready_single: assert property (pready |=> !pready)
        else $error("pready held past one cycle");
    chk_hole_refused: assert property (holeSetup |=> pslverr && prdata == 32'h0000_0000)
        else $error("unmapped access not refused");
    chk_bell_rings: assert property (bellWrite |=> doorbellRequest)
        else $error("doorbell write did not raise request");
    chk_bell_waits: assert property (doorbellRequest && !asyncAdvanceDone |=> doorbellRequest)
        else $error("doorbell dropped without advance");
    chk_bell_clears: assert property (doorbellRequest && asyncAdvanceDone && !bellWrite |=> !doorbellRequest)
        else $error("doorbell request not cleared after advance");
    chk_async_enable: assert property (cmdWrite && pstrb[0] |=> asyncScheduleEnable == $past(pwdata[CMD_ASYNC_EN]))
        else $error("async enable does not follow write");
    chk_period_enable: assert property (cmdWrite && pstrb[0] |=> periodicScheduleEnable == $past(pwdata[CMD_PERIOD_EN]))
        else $error("periodic enable does not follow write");
    chk_thresh_write: assert property (cmdWrite && pstrb[2] |=> thresholdCode == $past(pwdata[23:16]))
        else $error("threshold does not follow write");
    chk_reset_values: assert property ($fell(srst) |-> thresholdCode == RST_THRESH && !asyncScheduleEnable
        && !periodicScheduleEnable && !doorbellRequest)
        else $error("wrong values after reset");
    chk_irq_paced: assert property ($rose(irqOut) |-> $past(microFrameTick, 2))
        else $error("interrupt rose off a threshold boundary");

    // main scenarios reached
    cov_advance: cover property (doorbellRequest && asyncAdvanceDone);
    cov_irq: cover property ($rose(irqOut));
    cov_hole: cover property (pslverr);
endmodule // uhcf_command_fields_checker

bind uhcf_command_fields uhcf_command_fields_checker u_chk (.mclk(mclk), .srst(srst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .asyncAdvanceDone(asyncAdvanceDone), .doorbellRequest(doorbellRequest),
    .asyncScheduleEnable(asyncScheduleEnable), .periodicScheduleEnable(periodicScheduleEnable),
    .thresholdCode(thresholdCode), .microFrameTick(microFrameTick), .irqOut(irqOut));

/* File: tb/uhcf_command_fields_tb.sv */
// testbench: self-checking run of the host command fields block
`timescale 1ns/10ps
module uhcf_command_fields_tb;
    import uhcf_pkg::*;
    // ------------------------------------------------------------
    // stimulus and observed signals
    // ------------------------------------------------------------
    logic        mclk = 1'b0;
    logic        srst = 1'b1;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [3:0]  pstrb = 4'hF;
    logic        asyncAdvanceDone = 1'b0;
    logic        microFrameTick = 1'b0;
    logic [31:0] prdata, asyncListPointer, periodicListPointer, rd;
    logic        pready, pslverr, doorbellRequest, asyncScheduleEnable, periodicScheduleEnable, irqOut, err;
    logic [7:0]  thresholdCode;
    int          n_errors = 0;
    int          tests_run = 0;
    int          cycles = 0;

    always #5 mclk = ~mclk;

    uhcf_command_fields dut (.mclk(mclk), .srst(srst), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .asyncAdvanceDone(asyncAdvanceDone), .doorbellRequest(doorbellRequest),
        .asyncScheduleEnable(asyncScheduleEnable), .periodicScheduleEnable(periodicScheduleEnable),
        .asyncListPointer(asyncListPointer), .periodicListPointer(periodicListPointer),
        .thresholdCode(thresholdCode), .microFrameTick(microFrameTick), .irqOut(irqOut));

    // hang guard: the whole run needs well under a thousand cycles
    always @(posedge mclk) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            n_errors = n_errors + 1;
            tally_and_finish();
        end
    end

    // ------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------
    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        tests_run++;
        if (got !== exp) begin
            $display("unexpected %s: expected %h seen %h", what, exp, got);
            n_errors++;
        end
    endtask

    // one apb transfer; pready is sampled at the rising edge, outputs are looked at once settled
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge mclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'b1;
        do begin
            @(posedge mclk);
            n++;
        end while (pready !== 1'b1);
        // zero wait states: the answer stands in the first access cycle
        check("pready wait", 32'h1, n);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        // register updates from the completing edge are visible from here on
        @(negedge mclk);
    endtask

    task automatic wait_cycles(input int n);
        repeat (n) @(posedge mclk);
    endtask

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic test_reset();
        apb(1'b0, OFF_COMMAND, 32'h0);
        check("command after reset", 32'h0008_0000, rd);
        check("threshold port", 32'h08, {24'h0, thresholdCode});
        check("enables", 32'h0, {30'h0, asyncScheduleEnable, periodicScheduleEnable});
        check("bell request", 32'h0, {31'h0, doorbellRequest});
        $display("test reset done");
    endtask

    task automatic test_fields();
        logic [7:0] codes [7];
        codes = '{8'h01, 8'h02, 8'h04, 8'h08, 8'h10, 8'h20, 8'h40};
        // light reset bit set on purpose, reserved byte kept zero
        apb(1'b1, OFF_COMMAND, 32'h0040_00B0);
        apb(1'b0, OFF_COMMAND, 32'h0);
        check("command readback", 32'h0040_0030, rd);
        check("enables on", 32'h3, {30'h0, asyncScheduleEnable, periodicScheduleEnable});
        foreach (codes[i]) begin
            apb(1'b1, OFF_COMMAND, {8'h00, codes[i], 16'h0000});
            check("threshold port", {24'h0, codes[i]}, {24'h0, thresholdCode});
            apb(1'b0, OFF_COMMAND, 32'h0);
            check("threshold readback", {8'h00, codes[i], 16'h0000}, rd);
        end
        check("enables off", 32'h0, {30'h0, asyncScheduleEnable, periodicScheduleEnable});
        $display("test fields done");
    endtask

    task automatic test_doorbell();
        apb(1'b1, OFF_COMMAND, 32'h0001_0020);
        apb(1'b1, OFF_IRQ_EN, 32'h0000_0020);
        // ring only while the async schedule runs
        apb(1'b1, OFF_COMMAND, 32'h0001_0060);
        check("bell request", 32'h1, {31'h0, doorbellRequest});
        wait_cycles(4);
        apb(1'b0, OFF_STATUS, 32'h0);
        check("status before advance", 32'h0, rd);
        check("bell held", 32'h1, {31'h0, doorbellRequest});
        @(posedge mclk);
        asyncAdvanceDone <= 1'b1;
        @(posedge mclk);
        asyncAdvanceDone <= 1'b0;
        wait_cycles(2);
        apb(1'b0, OFF_STATUS, 32'h0);
        check("status flag", 32'h0000_0020, rd);
        apb(1'b0, OFF_COMMAND, 32'h0);
        check("bell cleared", 32'h0001_0020, rd);
        check("bell request", 32'h0, {31'h0, doorbellRequest});
        check("irq before tick", 32'h0, {31'h0, irqOut});
        @(posedge mclk);
        microFrameTick <= 1'b1;
        @(posedge mclk);
        microFrameTick <= 1'b0;
        wait_cycles(2);
        @(negedge mclk);
        check("irq at boundary", 32'h1, {31'h0, irqOut});
        apb(1'b1, OFF_STATUS, 32'h0000_0020);
        wait_cycles(2);
        @(negedge mclk);
        check("irq after clear", 32'h0, {31'h0, irqOut});
        $display("test doorbell done");
    endtask

    task automatic test_pointers();
        apb(1'b1, OFF_PERIODIC, 32'h1234_5000);
        apb(1'b1, OFF_ASYNC, 32'hABCD_E020);
        check("periodic port", 32'h1234_5000, periodicListPointer);
        check("async port", 32'hABCD_E020, asyncListPointer);
        apb(1'b0, OFF_ASYNC, 32'h0);
        check("async readback", 32'hABCD_E020, rd);
        // only the low byte lane is enabled, the upper bytes must survive
        @(posedge mclk);
        pstrb <= 4'h1;
        apb(1'b1, OFF_ASYNC, 32'hFFFF_FFFF);
        check("async lane merge", 32'hABCD_E0FF, asyncListPointer);
        @(posedge mclk);
        pstrb <= 4'hF;
        apb(1'b1, 12'h00C, 32'hFFFF_FFFF);
        check("hole write error", 32'h1, {31'h0, err});
        apb(1'b0, 12'h00C, 32'h0);
        check("hole read data", 32'h0, rd);
        apb(1'b0, OFF_COMMAND, 32'h0);
        check("command untouched", 32'h0001_0020, rd);
        $display("test pointers done");
    endtask

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        wait_cycles(12);
        srst <= 1'b0;
        test_reset();
        test_fields();
        test_doorbell();
        test_pointers();
        tally_and_finish();
    end
endmodule // uhcf_command_fields_tb
